// >>> frm_regs.sv
`timescale 1ns/10ps
module frm_regs
  import frm_pkg::*;
#(
  parameter int NUM_RECORDS = 4,
  parameter int REMOTE_UNITS = 1
)
(
  // Clock and reset
  input wire logic mclk,
  input wire logic arst_n,
  // APB4 programming port
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [FRM_ADDR_W-1:0] paddr,
  input wire logic [FRM_DATA_W-1:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic [2:0] pprot,
  output logic [FRM_DATA_W-1:0] prdata,
  output logic pready,
  output logic pslverr,
  // Error sources
  input wire logic [NUM_RECORDS-1:0] err_event,
  input wire logic [NUM_RECORDS-1:0] err_uncorr,
  input wire logic unit_idle,
  // Controls to the fault unit
  output logic [4*NUM_RECORDS-1:0] record_control,
  output logic [31:0] ping_control,
  output logic [31:0] directed_ping,
  output logic [63:0] ping_target_mask,
  output logic [31:0] sm_enable,
  output logic [31:0] sm_inject,
  output logic [63:0] error_group_flags
);

  // ---------------------------------------------------------------
  // Elaboration checks
  // ---------------------------------------------------------------
  localparam bit LARGE_MAP = (REMOTE_UNITS >= FRM_LARGE_MAP_UNITS);

  if (NUM_RECORDS < 1 || NUM_RECORDS > FRM_MAX_RECORDS || REMOTE_UNITS < 0)
  begin : g_bad_params
    $error("NUM_RECORDS or REMOTE_UNITS out of range");
  end

  // ---------------------------------------------------------------
  // Reset release
  // ---------------------------------------------------------------
  logic rst_meta_reg;
  logic rst_n_reg;

  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      rst_meta_reg <= 1'b0;
      rst_n_reg <= 1'b0;
    end
    else
    begin
      rst_meta_reg <= 1'b1;
      rst_n_reg <= rst_meta_reg;
    end
  end

  // ---------------------------------------------------------------
  // Address decode
  // ---------------------------------------------------------------
  function automatic logic hit(input logic [15:0] a, input logic [15:0] n_ofs, input logic [15:0] l_ofs);
    hit = (a[15:2] == (LARGE_MAP ? l_ofs[15:2] : n_ofs[15:2]));
  endfunction : hit

  function automatic logic hit64(input logic [15:0] a, input logic [15:0] n_ofs, input logic [15:0] l_ofs);
    hit64 = (a[15:3] == (LARGE_MAP ? l_ofs[15:3] : n_ofs[15:3]));
  endfunction : hit64

  logic take;
  logic secure;
  logic full_strobe;
  logic [15:0] addr;
  logic rec_hit;
  logic [5:0] rec_idx;
  logic sel_key;
  logic sel_pingctl;
  logic sel_pingnow;
  logic sel_smen;
  logic sel_sminj;
  logic sel_mask;
  logic sel_group;
  logic sel_state;
  logic sel_ident;
  logic is_wide;

  assign take = psel & penable & ~pready;
  assign secure = ~pprot[1];
  assign full_strobe = &pstrb;
  assign addr = paddr;
  assign rec_idx = addr[11:6];
  assign rec_hit = (addr[15:12] == 4'h0) && (int'(rec_idx) < NUM_RECORDS) &&
                   (addr[5:3] <= FRM_REC_STATUS[5:3]);
  assign sel_key = hit(addr, FRM_OFS_KEY, FRM_LOFS_KEY);
  assign sel_pingctl = hit(addr, FRM_OFS_PINGCTL, FRM_LOFS_PINGCTL);
  assign sel_pingnow = hit(addr, FRM_OFS_PINGNOW, FRM_LOFS_PINGNOW);
  assign sel_smen = hit(addr, FRM_OFS_SMEN, FRM_LOFS_SMEN);
  assign sel_sminj = hit(addr, FRM_OFS_SMINJ, FRM_LOFS_SMINJ);
  assign sel_mask = hit64(addr, FRM_OFS_MASK, FRM_LOFS_MASK);
  assign sel_group = hit64(addr, FRM_OFS_GROUP, FRM_LOFS_GROUP);
  assign sel_state = hit(addr, FRM_OFS_STATE, FRM_LOFS_STATE);
  assign sel_ident = hit(addr, FRM_OFS_IDENT, FRM_LOFS_IDENT);
  assign is_wide = rec_hit | sel_mask | sel_group;

  // ---------------------------------------------------------------
  // Lock and key
  // ---------------------------------------------------------------
  frm_lock_e lock_reg;
  logic [15:3] pair_addr_reg;
  logic pair_half_reg;
  logic sec_wr;
  logic key_ok;
  logic wr_ok;

  assign sec_wr = take & pwrite & secure;
  assign key_ok = full_strobe && (pwdata[7:0] == FRM_KEY_VALUE);
  assign wr_ok = sec_wr & ~sel_key & full_strobe &
                 ((lock_reg == FRM_OPEN) ||
                  ((lock_reg == FRM_PAIR) && (pair_addr_reg == addr[15:3]) &&
                   (pair_half_reg != addr[2])));

  always_ff @(posedge mclk or negedge rst_n_reg)
  begin
    if (!rst_n_reg)
    begin
      lock_reg <= FRM_LOCKED;
      pair_addr_reg <= '0;
      pair_half_reg <= 1'b0;
    end
    else if (sec_wr)
    begin
      pair_addr_reg <= addr[15:3];
      pair_half_reg <= addr[2];
      case (lock_reg)
        FRM_LOCKED, FRM_OPEN, FRM_PAIR:
        begin
          if (sel_key)
            lock_reg <= key_ok ? FRM_OPEN : FRM_LOCKED;
          else if (wr_ok && lock_reg == FRM_OPEN && is_wide)
            lock_reg <= FRM_PAIR;
          else
            lock_reg <= FRM_LOCKED;
        end
        default:
          lock_reg <= FRM_LOCKED;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Error records
  // ---------------------------------------------------------------
  logic [3:0] ctl_reg [NUM_RECORDS];
  logic [31:0] status_reg [NUM_RECORDS];

  for (genvar n = 0; n < NUM_RECORDS; n++)
  begin : g_rec
    logic sel_n;
    logic [31:0] clr;
    logic [31:0] set;

    assign sel_n = wr_ok && rec_hit && (int'(rec_idx) == n);
    always_comb
    begin
      clr = '0;
      set = '0;
      if (sel_n && addr[5:2] == FRM_REC_STATUS[5:2])
        clr = pwdata; // Write one to clear
      if (err_event[n] && ctl_reg[n][FRM_CTL_ED])
      begin
        set[FRM_ST_VALID] = 1'b1;
        set[FRM_ST_UNCORR] = err_uncorr[n];
        set[FRM_ST_OVERFLOW] = status_reg[n][FRM_ST_VALID];
      end
    end

    always_ff @(posedge mclk or negedge rst_n_reg)
    begin
      if (!rst_n_reg)
        ctl_reg[n] <= FRM_CONTROL_RST;
      else if (sel_n && addr[5:2] == FRM_REC_CONTROL[5:2])
        ctl_reg[n] <= pwdata[3:0];
    end

    // Hardware set wins over software clear
    always_ff @(posedge mclk or negedge rst_n_reg)
    begin
      if (!rst_n_reg)
        status_reg[n] <= FRM_ZERO_RST;
      else
        status_reg[n] <= (status_reg[n] & ~clr) | set;
    end
  end

  // ---------------------------------------------------------------
  // Global registers
  // ---------------------------------------------------------------
  always_ff @(posedge mclk or negedge rst_n_reg)
  begin
    if (!rst_n_reg)
    begin
      ping_control <= FRM_ZERO_RST;
      directed_ping <= FRM_ZERO_RST;
      ping_target_mask <= '0;
      sm_enable <= FRM_ZERO_RST;
      sm_inject <= FRM_ZERO_RST;
    end
    else if (wr_ok)
    begin
      if (sel_pingctl)
        ping_control <= pwdata;
      if (sel_pingnow)
        directed_ping <= pwdata;
      if (sel_smen)
        sm_enable <= pwdata;
      if (sel_sminj)
        sm_inject <= pwdata;
      if (sel_mask && !addr[2])
        ping_target_mask[31:0] <= pwdata;
      if (sel_mask && addr[2])
        ping_target_mask[63:32] <= pwdata;
    end
  end

  always_ff @(posedge mclk or negedge rst_n_reg)
  begin
    if (!rst_n_reg)
    begin
      record_control <= '0;
      error_group_flags <= '0;
    end
    else
    begin
      for (int n = 0; n < NUM_RECORDS; n++)
      begin
        record_control[4*n +: 4] <= ctl_reg[n];
        error_group_flags[n] <= status_reg[n][FRM_ST_VALID];
      end
    end
  end

  // ---------------------------------------------------------------
  // Read path
  // ---------------------------------------------------------------
  logic [31:0] rdata;
  logic [63:0] rec_word;

  always_comb
  begin
    rec_word = '0;
    for (int n = 0; n < NUM_RECORDS; n++)
    begin
      if (int'(rec_idx) == n)
      begin
        case (addr[5:3])
          FRM_REC_FEATURES[5:3]: rec_word = {32'h0000_0000, FRM_FEATURES_RST};
          FRM_REC_CONTROL[5:3]: rec_word = {60'h0, ctl_reg[n]};
          FRM_REC_STATUS[5:3]: rec_word = {32'h0000_0000, status_reg[n]};
          default: rec_word = '0;
        endcase
      end
    end
    if (!secure)
      rdata = '0;
    else if (rec_hit)
      rdata = addr[2] ? rec_word[63:32] : rec_word[31:0];
    else if (sel_group)
      rdata = addr[2] ? error_group_flags[63:32] : error_group_flags[31:0];
    else if (sel_key)
      rdata = (lock_reg != FRM_LOCKED) ? {24'h0, FRM_KEY_VALUE} : FRM_ZERO_RST;
    else if (sel_pingctl)
      rdata = ping_control;
    else if (sel_pingnow)
      rdata = directed_ping;
    else if (sel_mask)
      rdata = addr[2] ? ping_target_mask[63:32] : ping_target_mask[31:0];
    else if (sel_state)
      rdata = {30'h0, lock_reg != FRM_LOCKED, unit_idle};
    else if (sel_ident)
      rdata = 32'(NUM_RECORDS);
    else
      rdata = '0;
  end

  // ---------------------------------------------------------------
  // APB answer
  // ---------------------------------------------------------------
  always_ff @(posedge mclk or negedge rst_n_reg)
  begin
    if (!rst_n_reg)
    begin
      pready <= 1'b0;
      prdata <= FRM_ZERO_RST;
      pslverr <= 1'b0;
    end
    else
    begin
      pready <= take;
      pslverr <= 1'b0;
      prdata <= (take && !pwrite) ? rdata : FRM_ZERO_RST;
    end
  end

endmodule : frm_regs

// >>> frm_pkg.sv
// ---------------------------------------------------------------
// Fault register map constants
// ---------------------------------------------------------------
package frm_pkg;

  localparam int FRM_ADDR_W = 16;
  localparam int FRM_DATA_W = 32;
  localparam int FRM_LARGE_MAP_UNITS = 54;
  localparam int FRM_MAX_RECORDS = 56;

  // Record layout
  localparam logic [15:0] FRM_REC_STRIDE = 16'h0040;
  localparam logic [15:0] FRM_REC_FEATURES = 16'h0000;
  localparam logic [15:0] FRM_REC_CONTROL = 16'h0008;
  localparam logic [15:0] FRM_REC_STATUS = 16'h0010;

  // Normal map
  localparam logic [15:0] FRM_OFS_GROUP = 16'h0E00;
  localparam logic [15:0] FRM_OFS_KEY = 16'h0EA0;
  localparam logic [15:0] FRM_OFS_PINGCTL = 16'h0EA4;
  localparam logic [15:0] FRM_OFS_PINGNOW = 16'h0EA8;
  localparam logic [15:0] FRM_OFS_SMEN = 16'h0EB0;
  localparam logic [15:0] FRM_OFS_SMINJ = 16'h0EB4;
  localparam logic [15:0] FRM_OFS_MASK = 16'h0EC0;
  localparam logic [15:0] FRM_OFS_STATE = 16'h0F00;
  localparam logic [15:0] FRM_OFS_IDENT = 16'h0FC8;

  // Large-page map
  localparam logic [15:0] FRM_LOFS_GROUP = 16'hE000;
  localparam logic [15:0] FRM_LOFS_KEY = 16'hE0A0;
  localparam logic [15:0] FRM_LOFS_PINGCTL = 16'hE0A4;
  localparam logic [15:0] FRM_LOFS_PINGNOW = 16'hE0A8;
  localparam logic [15:0] FRM_LOFS_SMEN = 16'hE0B0;
  localparam logic [15:0] FRM_LOFS_SMINJ = 16'hE0B4;
  localparam logic [15:0] FRM_LOFS_MASK = 16'hE0C0;
  localparam logic [15:0] FRM_LOFS_STATE = 16'hE100;
  localparam logic [15:0] FRM_LOFS_IDENT = 16'hE1C8;

  // Key and reset values
  localparam logic [7:0] FRM_KEY_VALUE = 8'hBE;
  localparam logic [31:0] FRM_FEATURES_RST = 32'h0000_00A2;
  localparam logic [3:0] FRM_CONTROL_RST = 4'h1;
  localparam logic [31:0] FRM_ZERO_RST = 32'h0000_0000;

  // Field positions
  localparam int FRM_CTL_ED = 0;
  localparam int FRM_ST_OVERFLOW = 27;
  localparam int FRM_ST_UNCORR = 29;
  localparam int FRM_ST_VALID = 30;
  localparam int FRM_STATE_IDLE = 0;
  localparam int FRM_STATE_UNLOCKED = 1;

  typedef enum logic [2:0] {
    FRM_LOCKED = 3'b001,
    FRM_OPEN = 3'b010,
    FRM_PAIR = 3'b100
  } frm_lock_e;

endpackage : frm_pkg

// >>> frm_apb_req.sv
`timescale 1ns/10ps
module frm_apb_req
  import frm_pkg::*;
(
  // Clock
  input wire logic mclk,
  // APB4 requester
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [FRM_ADDR_W-1:0] paddr,
  output logic [FRM_DATA_W-1:0] pwdata,
  output logic [3:0] pstrb,
  output logic [2:0] pprot,
  input wire logic [FRM_DATA_W-1:0] prdata,
  input wire logic pready
);
  initial
  begin
    {psel, penable, pwrite} = 3'h0;
    paddr = 16'h0000;
    pwdata = 32'h0000_0000;
    pstrb = 4'h0;
    pprot = 3'h0;
  end

  // Held until pready is sampled, then released with inverted data
  task automatic xfer(input logic w, input logic [15:0] a, input logic [31:0] d, input logic [3:0] s,
    input logic ns, output logic [31:0] r);
    @(posedge mclk);
    #1;
    psel = 1'b1;
    pwrite = w;
    paddr = a;
    pwdata = d;
    pstrb = s;
    pprot = {1'b0, ns, 1'b0};
    @(posedge mclk);
    #1;
    penable = 1'b1;
    @(posedge mclk);
    while (pready !== 1'b1)
      @(posedge mclk);
    r = prdata;
    #1;
    {psel, penable} = 2'h0;
    paddr = ~a;
    pwdata = ~d;
  endtask : xfer
endmodule : frm_apb_req

// >>> frm_regs_asserts.sv
`timescale 1ns/10ps
module frm_regs_asserts
  import frm_pkg::*;
#(
  parameter int NUM_RECORDS = 4,
  parameter int REMOTE_UNITS = 1
)
(
  // Clock and reset
  input wire logic mclk,
  input wire logic arst_n,
  // Bus
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [3:0] pstrb,
  input wire logic [2:0] pprot,
  input wire logic [FRM_DATA_W-1:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Fault unit side
  input wire logic [NUM_RECORDS-1:0] err_event,
  input wire logic [4*NUM_RECORDS-1:0] record_control,
  input wire logic [31:0] ping_control,
  input wire logic [31:0] sm_enable,
  input wire logic [63:0] error_group_flags
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!arst_n);

  access_answer_a: assert property (psel && penable && !pready |=> pready)
    else $error("no answer one cycle after take");
  answer_pulse_a: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  no_slverr_a: assert property (!pslverr)
    else $error("error response seen");
  idle_data_a: assert property (!pready |-> prdata == 32'h0000_0000)
    else $error("read data outside answer");
  ns_read_a: assert property (pready && !pwrite && pprot[1] |-> prdata == 32'h0000_0000)
    else $error("non-secure read not zero");
  ns_write_a: assert property (pready && pwrite && pprot[1] |-> $stable(ping_control) && $stable(sm_enable))
    else $error("non-secure write took effect");
  part_strobe_a: assert property (pready && pwrite && pstrb != 4'hF |-> $stable(sm_enable))
    else $error("partial write took effect");
  ctl_cause_a: assert property ($changed(ping_control) |-> pready && pwrite && !pprot[1])
    else $error("ping control changed without write");
  event_log_a: assert property (err_event[0] ##1 record_control[0] |-> ##1 error_group_flags[0])
    else $error("event not flagged");

  cover property (pready && pwrite && !pprot[1]);
  cover property (pready && pprot[1]);
  cover property (err_event[0]);
endmodule : frm_regs_asserts

bind frm_regs frm_regs_asserts #(.NUM_RECORDS(NUM_RECORDS), .REMOTE_UNITS(REMOTE_UNITS)) u_chk (
  .mclk(mclk), .arst_n(arst_n), .psel(psel), .penable(penable), .pwrite(pwrite), .pstrb(pstrb),
  .pprot(pprot), .prdata(prdata), .pready(pready), .pslverr(pslverr), .err_event(err_event),
  .record_control(record_control), .ping_control(ping_control), .sm_enable(sm_enable),
  .error_group_flags(error_group_flags));

// >>> tb_fault_register_map.sv
`timescale 1ns/10ps
`define CHK(g, e) \
  begin \
    checks_done++; \
    if ((g) !== (e)) \
    begin \
      n_errors++; \
      $display("unexpected at %0t: got %h expected %h", $time, (g), (e)); \
    end \
  end
module tb_fault_register_map;
  import frm_pkg::*;
  logic mclk, arst_n, psel, penable, pwrite, pready, pslverr, unit_idle;
  logic [15:0] paddr, record_control;
  logic [31:0] pwdata, prdata, ping_control, directed_ping, sm_enable, sm_inject;
  logic [3:0] pstrb, err_event, err_uncorr;
  logic [2:0] pprot;
  logic [63:0] ping_target_mask, error_group_flags;
  logic large_sel, pready_l;
  logic [31:0] prdata_l, ping_control_l;
  int n_errors = 0;
  int checks_done = 0;
  int cycles = 0;

  frm_apb_req u_req (.mclk(mclk), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pstrb(pstrb), .pprot(pprot), .prdata(large_sel ? prdata_l : prdata),
    .pready(large_sel ? pready_l : pready));

  // Large-page map copy, reached only while large_sel is high
  frm_regs #(.NUM_RECORDS(4), .REMOTE_UNITS(54)) dut_large (.mclk(mclk), .arst_n(arst_n),
    .psel(psel & large_sel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pstrb(pstrb), .pprot(pprot), .prdata(prdata_l), .pready(pready_l), .pslverr(), .err_event(err_event),
    .err_uncorr(err_uncorr), .unit_idle(unit_idle), .record_control(), .ping_control(ping_control_l),
    .directed_ping(), .ping_target_mask(), .sm_enable(), .sm_inject(), .error_group_flags());

  frm_regs #(.NUM_RECORDS(4), .REMOTE_UNITS(1)) dut (.mclk(mclk), .arst_n(arst_n), .psel(psel & ~large_sel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pprot(pprot),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .err_event(err_event), .err_uncorr(err_uncorr),
    .unit_idle(unit_idle), .record_control(record_control), .ping_control(ping_control),
    .directed_ping(directed_ping), .ping_target_mask(ping_target_mask), .sm_enable(sm_enable),
    .sm_inject(sm_inject), .error_group_flags(error_group_flags));

  initial
  begin
    mclk = 1'b0;
    forever
      #2 mclk = ~mclk;
  end

  always @(posedge mclk)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      n_errors++;
      print_verdict();
    end
  end

  task automatic print_verdict();
    $display("errors %0d checks %0d", n_errors, checks_done);
    if (n_errors == 0 && checks_done > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : print_verdict

  task automatic wr(input logic [15:0] a, input logic [31:0] d, input logic [3:0] s = 4'hF, input logic ns = 1'b0);
    logic [31:0] r;
    u_req.xfer(1'b1, a, d, s, ns, r);
  endtask : wr

  task automatic rdc(input logic [15:0] a, input logic [31:0] e, input logic ns = 1'b0);
    logic [31:0] r;
    u_req.xfer(1'b0, a, 32'h0000_0000, 4'h0, ns, r);
    `CHK(r, e)
  endtask : rdc

  task automatic ev(input logic [3:0] m);
    @(posedge mclk);
    #1;
    err_event = m;
    err_uncorr = m;
    @(posedge mclk);
    #1;
    err_event = 4'b0000;
    @(posedge mclk);
    #1;
  endtask : ev

  // Only mapped offsets are ever addressed
  task automatic t_reset();
    rdc(FRM_OFS_KEY, 32'h0000_0000);
    `CHK(record_control, 16'h1111)
    rdc(FRM_OFS_IDENT, 32'h0000_0004);
    rdc(FRM_OFS_STATE, 32'h0000_0001);
    rdc(16'h0040, FRM_FEATURES_RST);
    rdc(16'h0048, 32'h0000_0001);
    rdc(FRM_OFS_GROUP, 32'h0000_0000);
  endtask : t_reset

  task automatic t_lock();
    wr(FRM_OFS_PINGCTL, 32'h1234_5678);
    `CHK(ping_control, 32'h0000_0000)
    wr(FRM_OFS_KEY, 32'h0000_00BE);
    rdc(FRM_OFS_STATE, 32'h0000_0003);
    rdc(FRM_OFS_KEY, 32'h0000_00BE);
    wr(FRM_OFS_PINGCTL, 32'h1234_5678);
    `CHK(ping_control, 32'h1234_5678)
    wr(FRM_OFS_PINGNOW, 32'h0000_0001);
    `CHK(directed_ping, 32'h0000_0000)
    rdc(FRM_OFS_PINGCTL, 32'h1234_5678);
    wr(FRM_OFS_KEY, 32'h0000_00BE);
    wr(FRM_OFS_PINGNOW, 32'h0000_0003);
    `CHK(directed_ping, 32'h0000_0003)
    rdc(FRM_OFS_PINGNOW, 32'h0000_0003);
    wr(FRM_OFS_KEY, 32'h0000_00BE);
    wr(FRM_OFS_KEY, 32'h0000_01BF);
    rdc(FRM_OFS_KEY, 32'h0000_0000);
  endtask : t_lock

  task automatic t_secure();
    wr(FRM_OFS_KEY, 32'h0000_00BE, 4'hF, 1'b1);
    rdc(FRM_OFS_KEY, 32'h0000_0000);
    wr(FRM_OFS_KEY, 32'h0000_00BE);
    rdc(FRM_OFS_KEY, 32'h0000_0000, 1'b1);
    wr(FRM_OFS_SMEN, 32'h0000_000F, 4'hF, 1'b1);
    `CHK(sm_enable, 32'h0000_0000)
    rdc(FRM_OFS_KEY, 32'h0000_00BE);
    wr(FRM_OFS_SMEN, 32'h0000_000F, 4'h3);
    `CHK(sm_enable, 32'h0000_0000)
    rdc(FRM_OFS_KEY, 32'h0000_0000);
  endtask : t_secure

  task automatic t_pair();
    wr(FRM_OFS_KEY, 32'h0000_00BE);
    wr(FRM_OFS_MASK + 16'h0004, 32'hA5A5_0001);
    wr(FRM_OFS_MASK, 32'h0000_0F0F);
    `CHK(ping_target_mask, 64'hA5A5_0001_0000_0F0F)
    wr(FRM_OFS_MASK + 16'h0004, 32'hFFFF_FFFF);
    rdc(FRM_OFS_MASK + 16'h0004, 32'hA5A5_0001);
    wr(FRM_OFS_KEY, 32'h0000_00BE);
    wr(FRM_OFS_SMEN, 32'h8000_0001);
    `CHK(sm_enable, 32'h8000_0001)
    wr(FRM_OFS_KEY, 32'h0000_00BE);
    wr(FRM_OFS_SMINJ, 32'h0000_0010);
    `CHK(sm_inject, 32'h0000_0010)
    wr(FRM_OFS_KEY, 32'h0000_00BE);
    wr(16'h0048, 32'hFFFF_FFF0);
    rdc(16'h0048, 32'h0000_0000);
  endtask : t_pair

  task automatic t_event();
    ev(4'b0001);
    `CHK(error_group_flags, 64'h0000_0000_0000_0001)
    rdc(16'h0010, 32'h6000_0000);
    rdc(FRM_OFS_GROUP, 32'h0000_0001);
    ev(4'b0001);
    rdc(16'h0010, 32'h6800_0000);
    wr(FRM_OFS_KEY, 32'h0000_00BE);
    wr(16'h0010, 32'hFFFF_FFFF);
    rdc(16'h0010, 32'h0000_0000);
    ev(4'b0010);
    rdc(16'h0050, 32'h0000_0000);
    wr(FRM_OFS_KEY, 32'h0000_00BE);
    wr(16'h0048, 32'h0000_0001);
    `CHK(record_control[7:4], 4'h1)
  endtask : t_event

  task automatic t_large();
    large_sel = 1'b1;
    wr(FRM_LOFS_KEY, 32'h0000_00BE);
    rdc(FRM_LOFS_STATE, 32'h0000_0003);
    wr(FRM_LOFS_PINGCTL, 32'h0000_5A5A);
    `CHK(ping_control_l, 32'h0000_5A5A)
    rdc(FRM_LOFS_IDENT, 32'h0000_0004);
    rdc(FRM_LOFS_KEY, 32'h0000_0000);
    rdc(16'h0048, 32'h0000_0001);
    large_sel = 1'b0;
  endtask : t_large

  task automatic t_rst_mid();
    @(posedge mclk);
    #1;
    arst_n = 1'b0;
    repeat (3)
      @(posedge mclk);
    #1;
    arst_n = 1'b1;
    repeat (3)
      @(posedge mclk);
    #1;
    `CHK(ping_control, 32'h0000_0000)
    `CHK(ping_control_l, 32'h0000_0000)
    `CHK(ping_target_mask, 64'h0000_0000_0000_0000)
    `CHK(sm_enable, 32'h0000_0000)
    `CHK(record_control, 16'h1111)
    rdc(FRM_OFS_KEY, 32'h0000_0000);
  endtask : t_rst_mid

  initial
  begin
    arst_n = 1'b0;
    err_event = 4'b0000;
    err_uncorr = 4'b0000;
    unit_idle = 1'b1;
    large_sel = 1'b0;
    repeat (3)
      @(posedge mclk);
    #1;
    arst_n = 1'b1;
    repeat (3)
      @(posedge mclk);
    t_reset();
    t_lock();
    t_secure();
    t_pair();
    t_event();
    t_large();
    t_rst_mid();
    print_verdict();
  end
endmodule : tb_fault_register_map
